// >>> shared/bct_pkg.sv
/*
	Shared constants and types for the buffered capture timer channels:
	register byte addresses, field positions, reset values, encodings and
	the apb request bundle.
	Assumes a 32-bit apb master with 8-bit byte addresses, one word per
	register.
*/
package bct_pkg;

	// ------------------------------------------------------------
	// channel counts
	// ------------------------------------------------------------
	localparam int NCH  = 8;          // timer channels
	localparam int NBUF = 4;          // channels with holding registers

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] A_FUNC   = 8'h00; // channel_function_select
	localparam logic [7:0] A_FORCE  = 8'h04; // compare_force_strobe
	localparam logic [7:0] A_MASK7  = 8'h08; // channel7_port_mask
	localparam logic [7:0] A_DATA7  = 8'h0C; // channel7_port_data
	localparam logic [7:0] A_PORT   = 8'h10; // timer_port_data
	localparam logic [7:0] A_DIR    = 8'h14; // timer_port_direction
	localparam logic [7:0] A_ACTION = 8'h18; // compare action hi:lo
	localparam logic [7:0] A_EDGE   = 8'h1C; // capture edge hi:lo
	localparam logic [7:0] A_NOVW   = 8'h20; // capture_overwrite_control
	localparam logic [7:0] A_CSYS   = 8'h24; // capture_system_control
	localparam logic [7:0] A_MODCTL = 8'h28; // modulus_counter_control
	localparam logic [7:0] A_TCTL   = 8'h2C; // main counter control
	localparam logic [7:0] A_MODCNT = 8'h30; // modulus load / count
	localparam logic [7:0] A_COUNT  = 8'h34; // main counter value
	localparam logic [7:0] A_CHAN   = 8'h40; // channel_compare_value 0..7
	localparam logic [7:0] A_HOLD   = 8'h60; // capture holding 0..3
	localparam logic [7:0] A_ACCH   = 8'h70; // accumulator holding 0..3
	localparam logic [7:0] A_ACC    = 8'h80; // accumulator count 0..3

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CSYS_LATCH_QUEUE_SELECT = 0;     // latch_queue_select, 1 = latch
	localparam int CSYS_SAT  = 1;     // accumulator_saturate
	localparam int CSYS_PAIR = 2;     // pair enables at bits 2 and 3
	localparam int MODC_EN   = 0;     // modulus counter enable
	localparam int MODC_REP  = 1;     // 1 = reload each period
	localparam int MODC_FLAT = 2;     // force_latch_strobe, write only
	localparam int TCTL_EN   = 0;     // main counter enable
	localparam int TCTL_PR   = 1;     // prescaler select, 3 bits
	localparam int EDGE_RISE = 0;     // edge select low bit
	localparam int EDGE_FALL = 1;     // edge select high bit

	// ------------------------------------------------------------
	// encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0]  ACT_OFF    = 2'h0; // pin disconnected
	localparam logic [1:0]  ACT_TOGGLE = 2'h1;
	localparam logic [1:0]  ACT_LOW    = 2'h2;
	localparam logic [1:0]  ACT_HIGH   = 2'h3;
	localparam logic [7:0]  RST8       = 8'h00;
	localparam logic [15:0] RST16      = 16'h0000;
	localparam logic [7:0]  ACC_MAX    = 8'hFF;

	// ------------------------------------------------------------
	// apb request bundle, fields named as the bus publishes them
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// >>> verilog/buffered_capture_timer_channels.sv
/*
	Eight-channel capture/compare timer with four buffered capture
	channels, four pairable pulse accumulators, a modulus down-counter
	latch source, forced compares and a channel-7 port mask.
	Assumes an apb master on SYS_CLK and asynchronous timer pins.
*/
// Added by the designer: the APB interface to the registers and the address map.
//
// Behaviour
// - function select bit selects capture or compare
// - valid edge stores main counter value
// - no-overwrite capture waits for empty register
// - empty after read or latch; holding after read
// - latch mode copies capture to holding
// - latch mode without protection always overwrites
// - protected buffered channels write only empty targets
// - queue mode shifts capture into holding
// - queue holding read moves accumulator, clears
// - four 8-bit accumulators with holding registers
// - saturate bit stops unpaired accumulators at max
// - accumulator pairs combine to sixteen bits
// - latch events copy and clear accumulators
// - modulus counter gives periodic or single latch
// - word accesses see coherent 16-bit values
// - enabled compare drives pin, ignores direction
// - port writes latch while pin is owned
// - force compare acts, no flag, reads zero
// - channel-7 mask forces compare pin output
// - channel-7 compare copies data to masked pins
// - mask suppresses the channel's own action
// - action codes off, toggle, low, high
// - edge codes off, rise, fall, both
// - channel-7 data wins coinciding compares
`timescale 1ns/1ns
`default_nettype none

module buffered_capture_timer_channels #(
	parameter int PRE_W = 7                  // prescaler stages
)(
	input  wire logic              SYS_CLK,
	input  wire logic              RESET_N,
	input  wire bct_pkg::apb_req_t APB_REQ,
	output logic [31:0]            PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic [7:0]        TIMER_PIN_IN,
	output logic [7:0]             TIMER_PIN_OUT,
	output logic [7:0]             TIMER_PIN_OE,
	output logic                   MOD_ZERO_PULSE
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int NCH  = bct_pkg::NCH;
	localparam int NBUF = bct_pkg::NBUF;

	logic [7:0]  a;                           // request address
	logic [15:0] wd;                          // low half of write data
	logic        wr_done;                     // write takes effect
	logic        rd_take;                     // read data captured
	logic [31:0] rdata;                       // read mux
	logic        hit;                         // address is mapped

	logic [7:0]  ios_r;                       // channel_function_select
	logic [7:0]  mask7_r;                     // channel7_port_mask
	logic [7:0]  data7_r;                     // channel7_port_data
	logic [7:0]  port_r;                      // timer_port_data latch
	logic [7:0]  dir_r;                       // timer_port_direction
	logic [15:0] act_r;                       // mode:level per channel
	logic [15:0] edge_r;                      // fall:rise per channel
	logic [7:0]  novw_r;                      // no_overwrite_bit per ch
	logic [3:0]  csys_r;                      // capture_system_control
	logic [1:0]  modc_r;                      // repeat, enable
	logic [3:0]  tctl_r;                      // prescale, enable
	logic [7:0]  force_compare_bits;                         // force pulses this cycle

	logic [7:0]  s1_r, s2_r, s3_r;            // pin synchroniser
	logic [7:0]  lvl_r;                       // filtered pin level
	logic [7:0]  lvl_nxt;
	logic [7:0]  active;                      // selected edge seen
	logic [7:0]  cap_evt;                     // capture request

	logic [PRE_W-1:0] pre_r;                  // prescale counter
	logic [PRE_W-1:0] pre_mask;
	logic        tick;                        // counter step
	logic        tick_d_r;                    // counter just stepped
	logic [15:0] cnt_r;                       // main up-counter
	logic [15:0] mod_load_r;                  // modulus reload value
	logic [15:0] mod_cnt_r;                   // modulus down-counter
	logic        mod_hit;                     // modulus reached zero
	logic        mod_wr_zero;                 // zero written to modulus
	logic        flat_wr;                     // force latch written
	logic        latch_evt;                   // latch mode event

	logic [15:0] tc_r [NCH];                  // capture/compare values
	logic [7:0]  cap_full_r;                  // capture reg not read
	logic [15:0] hold_r [NBUF];               // capture holding
	logic [3:0]  hold_full_r;                 // holding not read
	logic [7:0]  cap_load;                    // capture reg loads
	logic [3:0]  hold_load;                   // holding reg loads
	logic [7:0]  cap_rd;                      // capture reg read
	logic [3:0]  hold_rd;                     // holding reg read

	logic [7:0]  acc_r [NBUF];                // pulse accumulators
	logic [7:0]  acc_nxt [NBUF];
	logic [7:0]  acch_r [NBUF];               // accumulator holding
	logic [3:0]  xfer;                        // move and clear

	logic [7:0]  cmp_hit;                     // compare match
	logic [7:0]  oc_r;                        // compare output level
	logic [7:0]  oc_nxt;
	logic [7:0]  drive;                       // timer owns pin

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	assign a  = APB_REQ.paddr;
	assign wd = APB_REQ.pwdata[15:0];
	// one wait state: data is sampled in the first access cycle and
	// read side effects happen on that same edge, so no capture can
	// slip between the sampled value and the empty marking
	assign rd_take = APB_REQ.psel & APB_REQ.penable & ~PREADY &
		~APB_REQ.pwrite;
	assign wr_done = APB_REQ.psel & APB_REQ.penable & PREADY &
		APB_REQ.pwrite;

	// read mux, every value sampled whole in one cycle
	always_comb
	begin
		rdata = 32'h0000_0000;
		hit   = 1'b1;
		case (a)
			bct_pkg::A_FUNC:   rdata[7:0]  = ios_r;
			bct_pkg::A_FORCE:  rdata       = 32'h0000_0000;
			bct_pkg::A_MASK7:  rdata[7:0]  = mask7_r;
			bct_pkg::A_DATA7:  rdata[7:0]  = data7_r;
			bct_pkg::A_PORT:   rdata[7:0]  = lvl_r;
			bct_pkg::A_DIR:    rdata[7:0]  = dir_r;
			bct_pkg::A_ACTION: rdata[15:0] = act_r;
			bct_pkg::A_EDGE:   rdata[15:0] = edge_r;
			bct_pkg::A_NOVW:   rdata[7:0]  = novw_r;
			bct_pkg::A_CSYS:   rdata[3:0]  = csys_r;
			bct_pkg::A_MODCTL: rdata[1:0]  = modc_r;
			bct_pkg::A_TCTL:   rdata[3:0]  = tctl_r;
			bct_pkg::A_MODCNT: rdata[15:0] = mod_cnt_r;
			bct_pkg::A_COUNT:  rdata[15:0] = cnt_r;
			default:
			begin
				hit = 1'b0;
				for (int i = 0; i < NCH; i++)
					if (a == bct_pkg::A_CHAN + 8'(i * 4))
					begin
						rdata[15:0] = tc_r[i];
						hit = 1'b1;
					end
				for (int i = 0; i < NBUF; i++)
				begin
					if (a == bct_pkg::A_HOLD + 8'(i * 4))
					begin
						rdata[15:0] = hold_r[i];
						hit = 1'b1;
					end
					if (a == bct_pkg::A_ACCH + 8'(i * 4))
					begin
						rdata[7:0] = acch_r[i];
						hit = 1'b1;
					end
					if (a == bct_pkg::A_ACC + 8'(i * 4))
					begin
						rdata[7:0] = acc_r[i];
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// handshake and registered answer
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end
		else
		begin
			PREADY  <= APB_REQ.psel & APB_REQ.penable & ~PREADY;
			PSLVERR <= APB_REQ.psel & APB_REQ.penable & ~PREADY & ~hit;
			if (rd_take)
				PRDATA <= rdata;
		end
	end

	// control registers written by software
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			ios_r   <= bct_pkg::RST8;
			mask7_r <= bct_pkg::RST8;
			data7_r <= bct_pkg::RST8;
			port_r  <= bct_pkg::RST8;
			dir_r   <= bct_pkg::RST8;
			act_r   <= bct_pkg::RST16;
			edge_r  <= bct_pkg::RST16;
			novw_r  <= bct_pkg::RST8;
			csys_r  <= 4'h0;
			modc_r  <= 2'h0;
			tctl_r  <= 4'h0;
		end
		else if (wr_done)
		begin
			case (a)
				bct_pkg::A_FUNC:   ios_r   <= wd[7:0];
				bct_pkg::A_MASK7:  mask7_r <= wd[7:0];
				bct_pkg::A_DATA7:  data7_r <= wd[7:0];
				bct_pkg::A_PORT:   port_r  <= wd[7:0];
				bct_pkg::A_DIR:    dir_r   <= wd[7:0];
				bct_pkg::A_ACTION: act_r   <= wd;
				bct_pkg::A_EDGE:   edge_r  <= wd;
				bct_pkg::A_NOVW:   novw_r  <= wd[7:0];
				bct_pkg::A_CSYS:   csys_r  <= wd[3:0];
				bct_pkg::A_MODCTL: modc_r  <= wd[1:0];
				bct_pkg::A_TCTL:   tctl_r  <= wd[3:0];
				default: ;
			endcase
		end
	end

	// strobes that are never stored
	assign force_compare_bits = (wr_done && a == bct_pkg::A_FORCE) ? wd[7:0] : 8'h00;
	assign flat_wr = wr_done && a == bct_pkg::A_MODCTL &&
		wd[bct_pkg::MODC_FLAT];
	assign mod_wr_zero = wr_done && a == bct_pkg::A_MODCNT &&
		wd == bct_pkg::RST16;

	// ------------------------------------------------------------
	// pin synchroniser and edge detection
	// ------------------------------------------------------------
	// a change is accepted only when stages two and three agree,
	// which also rejects a single-cycle glitch
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			s1_r  <= 8'h00;
			s2_r  <= 8'h00;
			s3_r  <= 8'h00;
			lvl_r <= 8'h00;
		end
		else
		begin
			s1_r  <= TIMER_PIN_IN;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));

	// edge select decode and capture requests
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			active[i] = (edge_r[2*i + bct_pkg::EDGE_RISE] &
				lvl_nxt[i] & ~lvl_r[i]) |
				(edge_r[2*i + bct_pkg::EDGE_FALL] &
				~lvl_nxt[i] & lvl_r[i]);
			cap_evt[i] = active[i] & ~ios_r[i];
		end
	end

	// ------------------------------------------------------------
	// main counter and modulus down-counter
	// ------------------------------------------------------------
	assign pre_mask = PRE_W'((8'h01 << tctl_r[3:1]) - 8'h01);
	assign tick = tctl_r[bct_pkg::TCTL_EN] &
		((pre_r & pre_mask) == pre_mask);
	assign mod_hit = modc_r[bct_pkg::MODC_EN] & tick &
		(mod_cnt_r == 16'h0001);
	assign latch_evt = csys_r[bct_pkg::CSYS_LATCH_QUEUE_SELECT] &
		(mod_hit | mod_wr_zero | flat_wr);

	// prescaler and free-running up-counter
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			pre_r    <= '0;
			cnt_r    <= bct_pkg::RST16;
			tick_d_r <= 1'b0;
		end
		else
		begin
			tick_d_r <= tick;
			if (tctl_r[bct_pkg::TCTL_EN])
				pre_r <= pre_r + 1'b1;
			if (tick)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// modulus counter: repeat reloads, single mode parks at zero
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			mod_load_r     <= bct_pkg::RST16;
			mod_cnt_r      <= bct_pkg::RST16;
			MOD_ZERO_PULSE <= 1'b0;
		end
		else
		begin
			MOD_ZERO_PULSE <= mod_hit;
			if (wr_done && a == bct_pkg::A_MODCNT)
			begin
				mod_load_r <= wd;
				mod_cnt_r  <= wd;
			end
			else if (mod_hit && modc_r[bct_pkg::MODC_REP])
				mod_cnt_r <= mod_load_r;
			else if (modc_r[bct_pkg::MODC_EN] && tick &&
				mod_cnt_r != bct_pkg::RST16)
				mod_cnt_r <= mod_cnt_r - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// capture and holding registers
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			cap_rd[i] = rd_take & ~ios_r[i] &
				(a == bct_pkg::A_CHAN + 8'(i * 4));
		for (int i = 0; i < NBUF; i++)
			hold_rd[i] = rd_take & (a == bct_pkg::A_HOLD + 8'(i * 4));
	end

	// load decisions per channel and mode
	always_comb
	begin
		hold_load = 4'h0;
		for (int i = 0; i < NCH; i++)
			cap_load[i] = cap_evt[i] &
				(~novw_r[i] | ~cap_full_r[i]);
		for (int i = 0; i < NBUF; i++)
		begin
			if (csys_r[bct_pkg::CSYS_LATCH_QUEUE_SELECT])
				hold_load[i] = latch_evt &
					(~novw_r[i] | ~hold_full_r[i]);
			else if (!novw_r[i])
				hold_load[i] = cap_evt[i];
			else
			begin
				// protected queue: shift only into an empty holding
				hold_load[i] = cap_evt[i] & cap_full_r[i] &
					~hold_full_r[i];
				cap_load[i] = cap_evt[i] &
					(~cap_full_r[i] | ~hold_full_r[i]);
			end
		end
	end

	// capture values and compare values share one register
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < NCH; i++)
				tc_r[i] <= bct_pkg::RST16;
			cap_full_r <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (cap_load[i])
					tc_r[i] <= cnt_r;
				else if (wr_done && a == bct_pkg::A_CHAN + 8'(i * 4))
					tc_r[i] <= wd;
			end
			// a capture in the clearing cycle keeps the register full
			// unbuffered channels keep their mark until read
			cap_full_r <= cap_load | (cap_full_r & ~cap_rd &
				{4'hF, ~hold_load});
		end
	end

	// holding registers take the old capture value
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < NBUF; i++)
				hold_r[i] <= bct_pkg::RST16;
			hold_full_r <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < NBUF; i++)
				if (hold_load[i])
					hold_r[i] <= tc_r[i];
			hold_full_r <= hold_load | (hold_full_r & ~hold_rd);
		end
	end

	// ------------------------------------------------------------
	// pulse accumulators
	// ------------------------------------------------------------
	// latch mode moves on latch events, queue mode on holding reads
	assign xfer = csys_r[bct_pkg::CSYS_LATCH_QUEUE_SELECT] ? {4{latch_evt}} :
		hold_rd;

	// next counts; an edge in the clearing cycle counts as one
	always_comb
	begin
		logic [15:0] sum16;
		logic        pair;
		logic        xp;
		sum16 = 16'h0000;
		pair  = 1'b0;
		xp    = 1'b0;
		for (int p = 0; p < NBUF / 2; p++)
		begin
			pair  = csys_r[bct_pkg::CSYS_PAIR + p];
			xp    = xfer[2*p] | xfer[2*p+1];
			sum16 = {acc_r[2*p+1], acc_r[2*p]} + 16'h0001;
			if (pair)
			begin
				// low channel's edges drive the sixteen-bit count
				if (xp)
					{acc_nxt[2*p+1], acc_nxt[2*p]} =
						{8'h00, 7'h00, active[2*p]};
				else if (active[2*p])
					{acc_nxt[2*p+1], acc_nxt[2*p]} = sum16;
				else
					{acc_nxt[2*p+1], acc_nxt[2*p]} =
						{acc_r[2*p+1], acc_r[2*p]};
			end
			else
			begin
				for (int k = 2*p; k < 2*p + 2; k++)
				begin
					if (xfer[k])
						acc_nxt[k] = {7'h00, active[k]};
					else if (active[k] && !(csys_r[bct_pkg::CSYS_SAT]
						&& acc_r[k] == bct_pkg::ACC_MAX))
						acc_nxt[k] = acc_r[k] + 8'h01;
					else
						acc_nxt[k] = acc_r[k];
				end
			end
		end
	end

	// accumulator and holding storage
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < NBUF; i++)
			begin
				acc_r[i]  <= bct_pkg::RST8;
				acch_r[i] <= bct_pkg::RST8;
			end
		end
		else
		begin
			for (int i = 0; i < NBUF; i++)
			begin
				acc_r[i] <= acc_nxt[i];
				// a paired half follows its partner's move
				if (xfer[i] || (csys_r[bct_pkg::CSYS_PAIR + i/2] &&
					xfer[i ^ 1]))
					acch_r[i] <= acc_r[i];
			end
		end
	end

	// ------------------------------------------------------------
	// output compare and port pins
	// ------------------------------------------------------------
	// match is checked once per count, just after the counter steps
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			cmp_hit[i] = ios_r[i] & tick_d_r & (cnt_r == tc_r[i]);
	end

	// compare actions; the channel-7 mask owns its pins outright
	always_comb
	begin
		logic       fire;
		logic [1:0] act;
		fire   = 1'b0;
		act    = bct_pkg::ACT_OFF;
		oc_nxt = oc_r;
		for (int i = 0; i < NCH; i++)
		begin
			fire  = cmp_hit[i] | force_compare_bits[i];
			act   = act_r[2*i +: 2];
			drive[i] = ios_r[i] & ((act != bct_pkg::ACT_OFF) |
				mask7_r[i]);
			if (mask7_r[i])
			begin
				if (cmp_hit[7] | force_compare_bits[7])
					oc_nxt[i] = data7_r[i];
			end
			else if (fire)
			begin
				case (act)
					bct_pkg::ACT_TOGGLE: oc_nxt[i] = ~oc_r[i];
					bct_pkg::ACT_LOW:    oc_nxt[i] = 1'b0;
					bct_pkg::ACT_HIGH:   oc_nxt[i] = 1'b1;
					default:             oc_nxt[i] = oc_r[i];
				endcase
			end
		end
	end

	// pin drivers; the port latch shows only when the timer lets go
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			oc_r          <= 8'h00;
			TIMER_PIN_OUT <= 8'h00;
			TIMER_PIN_OE  <= 8'h00;
		end
		else
		begin
			oc_r          <= oc_nxt;
			TIMER_PIN_OUT <= (drive & oc_nxt) | (~drive & port_r);
			TIMER_PIN_OE  <= drive | dir_r;
		end
	end

endmodule

`default_nettype wire

// >>> sim/bct_pins.sv
/*
	Pin source model: drives the timer input levels on command.
	Assumes the bench feeds these levels to pins the timer does not drive.
*/
`timescale 1ns/1ns
`default_nettype none
module bct_pins (
	input  wire logic clk,
	output logic [7:0] level
);
	// all pins idle low
	initial level = 8'h00;
	// whole pulses, three cycles high and three low, never too short
	task automatic pulse(input int ch, input int k);
		repeat (k)
		begin
			@(posedge clk);
			level[ch] <= 1'b1;
			repeat (3) @(posedge clk);
			level[ch] <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/buffered_capture_timer_channels_chk.sv
/*
	Port checker for the capture timer: bus timing and read values.
	Assumes it is bound to the timer top module.
*/
`timescale 1ns/1ns
`default_nettype none
module buffered_capture_timer_channels_chk (
	input  wire logic              SYS_CLK,
	input  wire logic              RESET_N,
	input  wire bct_pkg::apb_req_t APB_REQ,
	input  wire logic [31:0]       PRDATA,
	input  wire logic              PREADY,
	input  wire logic              PSLVERR,
	input  wire logic              MOD_ZERO_PULSE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// one wait state on every transfer
	a_one_wait_state: assert property (APB_REQ.psel && APB_REQ.penable && !PREADY |=> PREADY) else $error("ready late");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
	a_ready_in_access: assert property (PREADY |-> APB_REQ.penable && $past(APB_REQ.penable)) else $error("ready early");
	a_err_misalign: assert property (PREADY && APB_REQ.paddr[1:0] != 2'h0 |-> PSLVERR) else $error("misalign ok");
	a_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000) else $error("bad error");
	a_force_reads_zero: assert property (PREADY && !APB_REQ.pwrite && APB_REQ.paddr == bct_pkg::A_FORCE |-> PRDATA == 32'h0000_0000) else $error("force read");
	a_chan_upper_zero: assert property (PREADY && !APB_REQ.pwrite && APB_REQ.paddr[7:5] == 3'h2 |-> PRDATA[31:16] == 16'h0000) else $error("upper bits");
	a_zero_pulse_one: assert property (MOD_ZERO_PULSE |=> !MOD_ZERO_PULSE) else $error("zero pulse");
	a_rdata_holds: assert property (!$stable(PRDATA) |-> PREADY && !APB_REQ.pwrite) else $error("rdata moved");
endmodule
`default_nettype wire

// >>> sim/buffered_capture_timer_channels_test.sv
/*
	Self-checking bench for the capture timer over apb.
	Assumes the pin source model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module buffered_capture_timer_channels_test;
	logic              clk;     // system clock
	logic              rst_n;   // sync reset
	bct_pkg::apb_req_t req;     // bus request
	logic [31:0]       prdata;  // read data
	logic [31:0]       rd;      // last read
	logic              pready;  // bus answer
	logic              pslverr; // bus error
	logic              mzp;     // modulus zero
	logic              errb;    // error seen
	logic [7:0]        src;     // source levels
	logic [7:0]        pout;    // timer levels
	logic [7:0]        poe;     // timer enables
	wire  [7:0]        pin;     // resolved pins
	int                n_errors;
	int                compares;
	int                n;
	int                c;
	int                acc_m;   // accumulator model
	assign pin = (poe & pout) | (~poe & src);
	buffered_capture_timer_channels dut (.SYS_CLK(clk), .RESET_N(rst_n),
		.APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TIMER_PIN_IN(pin), .TIMER_PIN_OUT(pout),
		.TIMER_PIN_OE(poe), .MOD_ZERO_PULSE(mzp));
	bct_pins pins (.clk(clk), .level(src));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	// one apb transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		r = prdata;
		errb = pslverr;
		req <= '0;
		if (k >= 20)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	function automatic int acc_next(int a, int k, logic sat);
		return sat ? ((a + k > 255) ? 255 : a + k) : (a + k) % 256;
	endfunction
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		req = '0;
		n_errors = 0;
		compares = 0;
		acc_m = 0;
		void'($urandom(32'h4183));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, bct_pkg::A_FUNC, 0, rd);
		chk(rd, 0);
		apb(1, bct_pkg::A_FUNC, 32'h0000_0010, rd);
		for (int m = 3; m >= 1; m--)
		begin
			apb(1, bct_pkg::A_ACTION, 32'(m) << 8, rd);
			apb(1, bct_pkg::A_FORCE, 32'h0000_0010, rd);
			repeat (2) @(posedge clk);
			chk(32'({poe[4], pout[4]}), 32'({1'b1, m != 2}));
		end
		apb(0, bct_pkg::A_FORCE, 0, rd);
		chk(rd, 0);
		apb(1, bct_pkg::A_PORT, 0, rd);
		chk(32'(pout[4]), 1);
		apb(1, bct_pkg::A_ACTION, 0, rd);
		apb(1, bct_pkg::A_DIR, 32'h0000_0010, rd);
		repeat (2) @(posedge clk);
		chk(32'({poe[4], pout[4]}), 32'h0000_0002);
		apb(1, bct_pkg::A_DIR, 0, rd);
		apb(1, bct_pkg::A_MASK7, 32'h0000_0010, rd);
		repeat (2) @(posedge clk);
		chk(32'(poe[4]), 1);
		apb(1, bct_pkg::A_MASK7, 0, rd);
		repeat (2) @(posedge clk);
		chk(32'(poe[4]), 0);
		// captures on ch0 and ch4 and counts on ch1, rising edges
		apb(1, bct_pkg::A_FUNC, 0, rd);
		apb(1, bct_pkg::A_EDGE, 32'h0000_0105, rd);
		for (int p = 0; p < 2; p++)
		begin
			apb(1, bct_pkg::A_TCTL, 1, rd);
			repeat ($urandom % 50 + 5) @(posedge clk);
			apb(1, bct_pkg::A_TCTL, 0, rd);
			if (p == 0)
			begin
				apb(0, bct_pkg::A_COUNT, 0, rd);
				c = rd;
			end
			pins.pulse(0, 1);
			pins.pulse(4, 1);
			repeat (8) @(posedge clk);
			if (p == 0)
			begin
				apb(0, bct_pkg::A_CHAN, 0, rd);
				chk(rd, c);
				apb(1, bct_pkg::A_NOVW, 32'h0000_0011, rd);
				pins.pulse(0, 1);
			end
		end
		apb(0, bct_pkg::A_CHAN, 0, rd);
		chk(rd, c);
		apb(0, bct_pkg::A_CHAN + 8'h10, 0, rd);
		chk(rd, c);
		n = $urandom % 20 + 1;
		pins.pulse(1, n);
		acc_m = acc_next(acc_m, n, 1'b0);
		repeat (8) @(posedge clk);
		apb(0, bct_pkg::A_ACC + 8'h04, 0, rd);
		chk(rd, acc_m);
		apb(1, bct_pkg::A_CSYS, 1, rd);
		apb(1, bct_pkg::A_MODCTL, 32'h0000_0004, rd);
		apb(0, bct_pkg::A_ACCH + 8'h04, 0, rd);
		chk(rd, acc_m);
		acc_m = 0;
		apb(0, bct_pkg::A_ACC + 8'h04, 0, rd);
		chk(rd, acc_m);
		apb(1, bct_pkg::A_CSYS, 3, rd);
		pins.pulse(1, 260);
		acc_m = acc_next(acc_m, 260, 1'b1);
		repeat (8) @(posedge clk);
		apb(0, bct_pkg::A_ACC + 8'h04, 0, rd);
		chk(rd, acc_m);
		apb(0, 8'hFC, 0, rd);
		chk({rd[30:0], errb}, 1);
		apb(0, 8'h02, 0, rd);
		chk(32'(errb), 1);
		// single-shot modulus: one zero pulse only
		apb(1, bct_pkg::A_TCTL, 1, rd);
		apb(1, bct_pkg::A_MODCTL, 1, rd);
		apb(1, bct_pkg::A_MODCNT, 3, rd);
		n = 0;
		repeat (60)
		begin
			@(posedge clk);
			n += int'(mzp);
		end
		chk(n, 1);
		tally_and_finish();
	end
endmodule
bind buffered_capture_timer_channels buffered_capture_timer_channels_chk chk (
	.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .APB_REQ(APB_REQ),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.MOD_ZERO_PULSE(MOD_ZERO_PULSE));
`default_nettype wire
